/* capture_pkg.sv */
package capture_pkg;

	// Word indices of the registers; byte address is four times the index
	localparam logic [29:0] REG_IDX_CONFIG = 30'h0000_0001;
	localparam logic [29:0] REG_IDX_BUFCTRL = 30'h0000_000F;
	localparam logic [29:0] REG_IDX_STATUS = 30'h0000_0010;

	localparam int unsigned CFG_RESYNC_SRC_BIT = 14;
	localparam int unsigned BUF_DUAL_PORT_BIT = 12;
	localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
	localparam logic [31:0] BUFCTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] CONFIG_WMASK = 32'h0000_4000;
	localparam logic [31:0] BUFCTRL_WMASK = 32'h0000_1000;

	localparam int unsigned ST_TRIM_BIT = 0;
	localparam int unsigned ST_PD_BIT = 1;
	localparam int unsigned ST_EXT_BIT = 2;
	localparam int unsigned ST_DDR_BIT = 3;
	localparam int unsigned ST_EDGE_BIT = 4;
	localparam int unsigned ST_RANGE_BIT = 5;
	localparam int unsigned ST_FILL_LSB = 16;

	// System-clock cycles of low, then of high, on the trim request
	localparam logic [7:0] TRIM_LOW_CYCLES = 8'h50;
	localparam logic [7:0] TRIM_HIGH_CYCLES = 8'h50;

	localparam int unsigned PIN_TRIM_REQ = 0;
	localparam int unsigned PIN_POWER_DOWN = 1;
	localparam int unsigned PIN_RANGE_PU = 2;
	localparam int unsigned PIN_RANGE_PD = 3;
	localparam int unsigned PIN_EDGE_PU = 4;
	localparam int unsigned PIN_EDGE_PD = 5;
	localparam int unsigned PIN_TRIM_WAIT = 6;
	localparam int unsigned PIN_SERIAL_CLK = 7;
	localparam int unsigned PIN_RESYNC_SE = 8;
	localparam int unsigned PIN_RESYNC_P = 9;
	localparam int unsigned PIN_RESYNC_N = 10;
	localparam int unsigned PIN_WRITE_REQ = 11;
	localparam int unsigned PIN_READ_REQ = 12;
	localparam int unsigned PIN_READ_CLK = 13;
	localparam int unsigned PIN_CAP_RESET = 14;
	localparam int unsigned PIN_COUNT = 15;

	typedef enum logic [1:0] {
		LVL_LOW = 2'h0,
		LVL_HIGH = 2'h1,
		LVL_MID = 2'h2
	} level_t;

	typedef enum logic [2:0] {
		ST_WAIT = 3'h1,
		ST_IDLE = 3'h2,
		ST_RUN = 3'h4
	} trim_state_t;

endpackage : capture_pkg

/* capture_reader.sv */
`timescale 1ns/1ps
module capture_reader (
	input wire logic clock_i,
	input wire logic read_go_i,
	input wire logic write_request_i,
	input wire logic [7:0] output_port_one_i,
	input wire logic [7:0] output_port_two_i,
	input wire logic output_strobe_one_i,
	output logic read_request_o,
	output logic read_clock_o
);
	logic [1:0] phase_q = 2'h0;
	logic strobe_q = 1'b0;
	logic [7:0] one_prev_q;
	logic [7:0] two_prev_q;
	logic [7:0] one_q[$];
	logic [7:0] two_q[$];
	int skew = 0;
	initial read_clock_o = 1'b0;
	initial read_request_o = 1'b0;
	// Read clock runs free; eight system clocks per period keeps the synchroniser happy
	always @(posedge clock_i) begin
		phase_q <= phase_q + 2'h1;
		if (phase_q == 2'h3) begin
			read_clock_o <= ~read_clock_o;
		end
		read_request_o <= read_go_i && !write_request_i;
		strobe_q <= output_strobe_one_i;
		one_prev_q <= output_port_one_i;
		two_prev_q <= output_port_two_i;
		// Bytes are logged on change, so test data never repeats back to back
		if (output_port_one_i !== one_prev_q) begin
			one_q.push_back(output_port_one_i);
			if (!(output_strobe_one_i && !strobe_q) && read_request_o) begin
				skew++;
			end
		end
		if (output_port_two_i !== two_prev_q) begin
			two_q.push_back(output_port_two_i);
		end
	end
endmodule : capture_reader

/* capture_readout_control.sv */
// Implementation choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
// Overview of operation
// RL1: Trim request low 80 cycles then high 80 cycles starts a calibration.
// RL2: Trim-active output is high exactly while a calibration runs.
// RL3: Power-down stops everything except the capture buffer; the code stops only the calibration sequencer.
// RL4: Normal mode: range low picks 600 mV, high picks 810 mV.
// RL5: Range pin floating or mid-supply selects extended control mode.
// RL6: Range pin driven: trim-wait pin picks the power-up calibration delay.
// RL7: Range pin floating: trim-wait pin is serial select, delay forced short.
// RL8: Normal mode: edge pin low or high picks the output transition edge.
// RL9: Edge pin floating or mid-supply selects double data rate output.
// RL10: Extended mode: edge pin is serial data, clocked by the shift clock.
// RL11: Outside extended mode the controller ties the shift clock low.
// RL12: Positive pulse on resync input resets the sample clock.
// RL13: Config bit 14 at index 1: 0 single-ended, 1 differential resync.
// RL14: Input sampled on both clock edges, giving two interleaved streams.
// RL15: Samples are stored as 8-bit offset binary.
// RL16: Capture buffer holds 4K samples, delivered over two byte ports.
// RL17: With read request high, port one updates on each read clock rise.
// RL18: Dual-port bit set: port two earlier sample, port one later sample.
// RL19: Dual-port bit clear: port two undriven, port one carries everything.
// RL20: With read request low, port one keeps the last byte read.
// RL21: Each strobe follows the read clock, aligned with its port data.
// RL22: Each read clock cycle with read request high reads one byte; with the dual-port bit set the code reads two.
// RL23: The controller never raises read request while write request is high.
// RL24: Capture reset input clears all buffer control logic; the code clears only the pointers and fill count, not BUFCTRL.
// RL25: Three-level pins decode to low, high and mid states driving modes.
module capture_readout_control
	import capture_pkg::*;
#(
	parameter int unsigned DEPTH = 4096,
	parameter int unsigned SHORT_WAIT_CYCLES = 1024,
	parameter int unsigned LONG_WAIT_CYCLES = 1048576,
	parameter int unsigned RUN_CYCLES = 2048
) (
	input wire logic clock_i,
	input wire logic srst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic trim_request_i,
	input wire logic power_down_input_i,
	input wire logic range_select_pu_i,
	input wire logic range_select_pd_i,
	input wire logic output_transition_edge_pu_i,
	input wire logic output_transition_edge_pd_i,
	input wire logic trim_wait_select_i,
	input wire logic serial_shift_clock_i,
	input wire logic sample_clock_resync_i,
	input wire logic sample_clock_resync_p_i,
	input wire logic sample_clock_resync_n_i,
	input wire logic write_request_i,
	input wire logic read_request_i,
	input wire logic read_clock_i,
	input wire logic capture_reset_i,
	input wire logic [7:0] sample_rise_i,
	input wire logic [7:0] sample_fall_i,
	input wire logic sample_valid_i,
	output logic trim_active_o,
	output logic power_down_o,
	output logic full_scale_810_o,
	output logic ext_ctrl_enable_o,
	output logic ddr_enable_o,
	output logic output_transition_edge_o,
	output logic serial_select_o,
	output logic serial_in_line_o,
	output logic serial_clock_o,
	output logic sample_clock_resync_o,
	output logic [7:0] output_port_one_o,
	output logic [7:0] output_port_two_o,
	output logic output_port_two_oe_o,
	output logic output_strobe_one_o,
	output logic output_strobe_two_o
);

	localparam int unsigned AW = $clog2(DEPTH);
	localparam int unsigned CW = $clog2(LONG_WAIT_CYCLES + RUN_CYCLES + 1);

	if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0 || AW > 15 || SHORT_WAIT_CYCLES == 0 ||
			LONG_WAIT_CYCLES < SHORT_WAIT_CYCLES || RUN_CYCLES == 0) begin : g_check
		$error("capture_readout_control: unsupported parameter values");
	end

	function automatic level_t decode_level(input logic pu, input logic pd);
		if (pu && pd) begin
			return LVL_HIGH;
		end else if (!pu && !pd) begin
			return LVL_LOW;
		end
		return LVL_MID;
	endfunction : decode_level

	function automatic logic [AW-1:0] step_idx(input logic [AW-1:0] p, input logic [1:0] n);
		return AW'(p + AW'(n));
	endfunction : step_idx

	// Core delivers two's complement; flipping the sign bit gives offset binary
	function automatic logic [7:0] offset_binary(input logic [7:0] s);
		return {~s[7], s[6:0]};
	endfunction : offset_binary

	// Pin synchronisers: three stages, a level is taken once stages two and three agree
	logic [PIN_COUNT-1:0] pins_raw;
	logic [PIN_COUNT-1:0] s1_q;
	logic [PIN_COUNT-1:0] s2_q;
	logic [PIN_COUNT-1:0] s3_q;
	logic [PIN_COUNT-1:0] pin_q;

	assign pins_raw[PIN_TRIM_REQ] = trim_request_i;
	assign pins_raw[PIN_POWER_DOWN] = power_down_input_i;
	assign pins_raw[PIN_RANGE_PU] = range_select_pu_i;
	assign pins_raw[PIN_RANGE_PD] = range_select_pd_i;
	assign pins_raw[PIN_EDGE_PU] = output_transition_edge_pu_i;
	assign pins_raw[PIN_EDGE_PD] = output_transition_edge_pd_i;
	assign pins_raw[PIN_TRIM_WAIT] = trim_wait_select_i;
	assign pins_raw[PIN_SERIAL_CLK] = serial_shift_clock_i;
	assign pins_raw[PIN_RESYNC_SE] = sample_clock_resync_i;
	assign pins_raw[PIN_RESYNC_P] = sample_clock_resync_p_i;
	assign pins_raw[PIN_RESYNC_N] = sample_clock_resync_n_i;
	assign pins_raw[PIN_WRITE_REQ] = write_request_i;
	assign pins_raw[PIN_READ_REQ] = read_request_i;
	assign pins_raw[PIN_READ_CLK] = read_clock_i;
	assign pins_raw[PIN_CAP_RESET] = capture_reset_i;

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			pin_q <= '0;
		end else begin
			s1_q <= pins_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			pin_q <= (s3_q & ~(s2_q ^ s3_q)) | (pin_q & (s2_q ^ s3_q));
		end
	end

	// Mode pins
	level_t range_lvl;
	level_t edge_lvl;
	logic ext_mode;
	logic power_down_q;
	logic ext_q;
	logic range_810_q;
	logic ddr_q;
	logic edge_q;
	logic serial_select_q;
	logic serial_data_q;
	logic serial_clk_q;

	assign range_lvl = decode_level(pin_q[PIN_RANGE_PU], pin_q[PIN_RANGE_PD]); // RL25
	assign edge_lvl = decode_level(pin_q[PIN_EDGE_PU], pin_q[PIN_EDGE_PD]); // RL25
	assign ext_mode = (range_lvl == LVL_MID); // RL5

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			power_down_q <= 1'b0;
			ext_q <= 1'b0;
			range_810_q <= 1'b0;
			ddr_q <= 1'b0;
			edge_q <= 1'b0;
			serial_select_q <= 1'b0;
			serial_data_q <= 1'b0;
			serial_clk_q <= 1'b0;
		end else begin
			power_down_q <= pin_q[PIN_POWER_DOWN]; // RL3
			ext_q <= ext_mode; // RL5
			range_810_q <= !ext_mode && (range_lvl == LVL_HIGH); // RL4
			ddr_q <= !ext_mode && (edge_lvl == LVL_MID); // RL9
			edge_q <= !ext_mode && (edge_lvl == LVL_HIGH); // RL8
			serial_select_q <= ext_mode && pin_q[PIN_TRIM_WAIT]; // RL7
			serial_data_q <= ext_mode && (edge_lvl == LVL_HIGH); // RL10
			// Shift clock is tied low outside extended mode; gating keeps noise out
			serial_clk_q <= ext_mode && pin_q[PIN_SERIAL_CLK]; // RL10 RL11
		end
	end

	// Trim request sequence detector
	logic [7:0] low_cnt_q;
	logic [7:0] high_cnt_q;
	logic armed_q;
	logic trim_start;

	assign trim_start = armed_q && (high_cnt_q == TRIM_HIGH_CYCLES); // RL1

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			low_cnt_q <= '0;
			high_cnt_q <= '0;
			armed_q <= 1'b0;
		end else if (!pin_q[PIN_TRIM_REQ]) begin
			high_cnt_q <= '0;
			armed_q <= 1'b0;
			if (low_cnt_q != TRIM_LOW_CYCLES) begin
				low_cnt_q <= low_cnt_q + 8'h01; // RL1
			end
		end else begin
			low_cnt_q <= '0;
			if (low_cnt_q == TRIM_LOW_CYCLES) begin
				armed_q <= 1'b1; // RL1
			end else if (trim_start) begin
				armed_q <= 1'b0;
			end
			if ((armed_q || low_cnt_q == TRIM_LOW_CYCLES) && high_cnt_q != TRIM_HIGH_CYCLES) begin
				high_cnt_q <= high_cnt_q + 8'h01; // RL1
			end
		end
	end

	// Calibration sequencer: power-up wait, then run; later runs on request
	trim_state_t state_q;
	trim_state_t state_d;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] wait_limit;
	logic trim_active_q;

	// Extended mode forces the short delay whatever the pin shows
	assign wait_limit = (!ext_mode && pin_q[PIN_TRIM_WAIT]) ? CW'(LONG_WAIT_CYCLES) :
		CW'(SHORT_WAIT_CYCLES); // RL6 RL7

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_WAIT: begin
				if (!power_down_q && cnt_q >= wait_limit - CW'(1)) begin
					state_d = ST_RUN; // RL6
				end
			end
			ST_IDLE: begin
				if (trim_start && !power_down_q) begin
					state_d = ST_RUN; // RL1 RL3
				end
			end
			ST_RUN: begin
				if (power_down_q || cnt_q == CW'(RUN_CYCLES - 1)) begin
					state_d = ST_IDLE; // RL3
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			state_q <= ST_WAIT;
			cnt_q <= '0;
			trim_active_q <= 1'b0;
		end else begin
			state_q <= state_d;
			trim_active_q <= (state_d == ST_RUN); // RL2
			if (state_d != state_q || state_q == ST_IDLE) begin
				cnt_q <= '0;
			end else if (!power_down_q) begin
				cnt_q <= cnt_q + CW'(1);
			end
		end
	end

	// Registers
	logic [31:0] config_q;
	logic [31:0] bufctrl_q;
	logic dual;

	assign dual = bufctrl_q[BUF_DUAL_PORT_BIT];

	// Resync source select and edge detect
	logic resync_sel;
	logic resync_prev_q;
	logic resync_pulse_q;

	assign resync_sel = config_q[CFG_RESYNC_SRC_BIT] ?
		(pin_q[PIN_RESYNC_P] && !pin_q[PIN_RESYNC_N]) : pin_q[PIN_RESYNC_SE]; // RL13

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			resync_prev_q <= 1'b0;
			resync_pulse_q <= 1'b0;
		end else begin
			resync_prev_q <= resync_sel;
			resync_pulse_q <= resync_sel && !resync_prev_q; // RL12
		end
	end

	// Capture buffer
	logic [7:0] mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] fill_q;
	logic [AW:0] fill_d;
	logic [1:0] rd_step;
	logic capture_clear;
	logic wr_en;
	logic rd_en;
	logic rclk_prev_q;
	logic [7:0] port_one_q;
	logic [7:0] port_two_q;
	logic port_two_oe_q;
	logic strobe_one_q;
	logic strobe_two_q;

	assign capture_clear = pin_q[PIN_CAP_RESET]; // RL24
	assign rd_step = dual ? 2'h2 : 2'h1; // RL18 RL19
	// Power-down leaves the buffer running; only the core stops
	assign wr_en = pin_q[PIN_WRITE_REQ] && sample_valid_i &&
		fill_q <= (AW+1)'(DEPTH - 2); // RL3 RL16
	// Reads are ignored during a write rather than corrupting the pointers
	assign rd_en = pin_q[PIN_READ_CLK] && !rclk_prev_q && pin_q[PIN_READ_REQ] &&
		!pin_q[PIN_WRITE_REQ] && fill_q >= (AW+1)'(rd_step); // RL22 RL23
	assign fill_d = fill_q + (wr_en ? (AW+1)'(2) : '0) - (rd_en ? (AW+1)'(rd_step) : '0);

	always_ff @(posedge clock_i) begin
		if (wr_en) begin
			mem_q[wr_ptr_q] <= offset_binary(sample_rise_i); // RL14 RL15
			mem_q[step_idx(wr_ptr_q, 2'h1)] <= offset_binary(sample_fall_i); // RL14 RL15
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i || capture_clear) begin
			wr_ptr_q <= '0; // RL24
			rd_ptr_q <= '0; // RL24
			fill_q <= '0; // RL24
		end else begin
			fill_q <= fill_d;
			if (wr_en) begin
				wr_ptr_q <= step_idx(wr_ptr_q, 2'h2);
			end
			if (rd_en) begin
				rd_ptr_q <= step_idx(rd_ptr_q, rd_step); // RL22
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			rclk_prev_q <= 1'b0;
			port_one_q <= '0;
			port_two_q <= '0;
			port_two_oe_q <= 1'b0;
			strobe_one_q <= 1'b0;
			strobe_two_q <= 1'b0;
		end else begin
			rclk_prev_q <= pin_q[PIN_READ_CLK];
			// Strobe rises in the same cycle as the data it marks
			strobe_one_q <= pin_q[PIN_READ_CLK]; // RL21
			strobe_two_q <= dual && pin_q[PIN_READ_CLK]; // RL21
			port_two_oe_q <= dual; // RL19
			if (rd_en && dual) begin
				port_two_q <= mem_q[rd_ptr_q]; // RL18
				port_one_q <= mem_q[step_idx(rd_ptr_q, 2'h1)]; // RL18
			end else if (rd_en) begin // RL20
				port_one_q <= mem_q[rd_ptr_q]; // RL17 RL19
			end
			if (!dual) begin
				port_two_q <= '0;
			end
		end
	end

	// AHB-Lite slave: writes zero-wait, reads one wait state
	logic accept;
	logic wr_pend_q;
	logic rd_pend_q;
	logic [29:0] addr_q;
	logic [31:0] hrdata_q;
	logic hready_q;
	logic [31:0] status_v;
	logic [31:0] read_v;

	assign accept = hsel_i && hready_i && htrans_i[1];

	always_comb begin
		status_v = '0;
		status_v[ST_TRIM_BIT] = trim_active_q;
		status_v[ST_PD_BIT] = power_down_q;
		status_v[ST_EXT_BIT] = ext_q;
		status_v[ST_DDR_BIT] = ddr_q;
		status_v[ST_EDGE_BIT] = edge_q;
		status_v[ST_RANGE_BIT] = range_810_q;
		status_v[ST_FILL_LSB +: AW+1] = fill_q;
		if (addr_q == REG_IDX_CONFIG) begin
			read_v = config_q;
		end else if (addr_q == REG_IDX_BUFCTRL) begin
			read_v = bufctrl_q;
		end else if (addr_q == REG_IDX_STATUS) begin
			read_v = status_v;
		end else begin
			read_v = '0;
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q <= '0;
			hrdata_q <= '0;
			hready_q <= 1'b1;
		end else begin
			if (hready_i) begin
				wr_pend_q <= accept && hwrite_i;
			end
			if (accept) begin
				addr_q <= haddr_i[31:2];
			end
			if (accept && !hwrite_i) begin
				rd_pend_q <= 1'b1;
				hready_q <= 1'b0;
			end else if (rd_pend_q) begin
				rd_pend_q <= 1'b0;
				hready_q <= 1'b1;
				hrdata_q <= read_v;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			config_q <= CONFIG_RESET;
			bufctrl_q <= BUFCTRL_RESET;
		end else if (wr_pend_q && hready_i) begin
			if (addr_q == REG_IDX_CONFIG) begin
				config_q <= hwdata_i & CONFIG_WMASK; // RL13
			end else if (addr_q == REG_IDX_BUFCTRL) begin
				bufctrl_q <= hwdata_i & BUFCTRL_WMASK; // RL18
			end
		end
	end

	assign hrdata_o = hrdata_q;
	assign hreadyout_o = hready_q;
	assign hresp_o = 1'b0 & hready_q;
	assign trim_active_o = trim_active_q;
	assign power_down_o = power_down_q;
	assign full_scale_810_o = range_810_q;
	assign ext_ctrl_enable_o = ext_q;
	assign ddr_enable_o = ddr_q;
	assign output_transition_edge_o = edge_q;
	assign serial_select_o = serial_select_q;
	assign serial_in_line_o = serial_data_q;
	assign serial_clock_o = serial_clk_q;
	assign sample_clock_resync_o = resync_pulse_q;
	assign output_port_one_o = port_one_q;
	assign output_port_two_o = port_two_q;
	assign output_port_two_oe_o = port_two_oe_q;
	assign output_strobe_one_o = strobe_one_q;
	assign output_strobe_two_o = strobe_two_q;

	// Checks
	logic [7:0] high_run_q;
	always_ff @(posedge clock_i) begin
		if (srst_i || !pin_q[PIN_TRIM_REQ]) begin
			high_run_q <= '0;
		end else if (high_run_q != 8'hFF) begin
			high_run_q <= high_run_q + 8'h01;
		end
	end

	a_trim_needs_high: assert property (@(posedge clock_i) disable iff (srst_i) // RL1
		trim_start |-> high_run_q == TRIM_HIGH_CYCLES && $past(low_cnt_q, 80) == TRIM_LOW_CYCLES)
		else $error("trim start without full low and high phases");
	a_trim_start_runs: assert property (@(posedge clock_i) disable iff (srst_i) // RL2
		(state_q == ST_IDLE && trim_start && !power_down_q) |=> trim_active_q && state_q == ST_RUN)
		else $error("trim request did not start a run");
	a_pd_stops_trim: assert property (@(posedge clock_i) disable iff (srst_i) // RL3
		power_down_q |=> !trim_active_q)
		else $error("calibration active during power-down");
	a_range_decode: assert property (@(posedge clock_i) disable iff (srst_i) // RL4
		range_lvl == LVL_LOW |=> !range_810_q && !ext_q)
		else $error("low range pin did not select 600 mV");
	a_ext_on_mid: assert property (@(posedge clock_i) disable iff (srst_i) // RL5
		range_lvl == LVL_MID |=> ext_q && !range_810_q && !ddr_q)
		else $error("mid range pin did not enter extended mode");
	a_ddr_on_mid: assert property (@(posedge clock_i) disable iff (srst_i) // RL9
		(range_lvl != LVL_MID && edge_lvl == LVL_MID) |=> ddr_q && !edge_q)
		else $error("floating edge pin did not select double data rate");
	a_shift_clk_gate: assert property (@(posedge clock_i) disable iff (srst_i) // RL11
		!ext_q |-> !serial_clk_q && !serial_select_q)
		else $error("serial lines active outside extended mode");
	a_resync_single: assert property (@(posedge clock_i) disable iff (srst_i) // RL12
		resync_pulse_q |=> !resync_pulse_q ##1 !resync_pulse_q)
		else $error("resync pulse longer than one cycle");
	a_fill_step: assert property (@(posedge clock_i) disable iff (srst_i) // RL22
		(rd_en && !wr_en && !capture_clear) |=> fill_q == $past(fill_q) - (AW+1)'($past(rd_step)))
		else $error("read did not remove its bytes");
	a_port_holds: assert property (@(posedge clock_i) disable iff (srst_i) // RL20
		!rd_en |=> $stable(port_one_q))
		else $error("port one changed without a read");
	a_strobe_align: assert property (@(posedge clock_i) disable iff (srst_i) // RL21
		$changed(port_one_q) |-> $rose(strobe_one_q))
		else $error("port data changed off its strobe edge");
	a_port_two_off: assert property (@(posedge clock_i) disable iff (srst_i) // RL19
		!dual |=> !port_two_oe_q && !strobe_two_q)
		else $error("port two driven in single-port mode");
	a_capture_clear: assert property (@(posedge clock_i) disable iff (srst_i) // RL24
		capture_clear |=> fill_q == '0 && rd_ptr_q == '0 && wr_ptr_q == '0)
		else $error("capture reset did not clear buffer control");

endmodule : capture_readout_control

/* test_capture_readout_control.sv */
`timescale 1ns/1ps
module test_capture_readout_control;
	import capture_pkg::*;
	localparam int unsigned RUN = 16;
	logic clock_i, srst_i, hsel_i, hwrite_i, trim_request_i, power_down_input_i;
	logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
	logic [1:0] htrans_i;
	logic [2:0] hsize_i;
	logic hreadyout_o, hresp_o, range_select_pu_i, range_select_pd_i, trim_wait_select_i;
	logic output_transition_edge_pu_i, output_transition_edge_pd_i, serial_shift_clock_i;
	logic sample_clock_resync_i, sample_clock_resync_p_i, sample_clock_resync_n_i;
	logic write_request_i, read_request_i, read_clock_i, capture_reset_i, sample_valid_i;
	logic [7:0] sample_rise_i, sample_fall_i, output_port_one_o, output_port_two_o;
	logic trim_active_o, power_down_o, full_scale_810_o, ext_ctrl_enable_o, ddr_enable_o;
	logic output_transition_edge_o, serial_select_o, serial_in_line_o, serial_clock_o;
	logic sample_clock_resync_o, output_port_two_oe_o, output_strobe_one_o;
	logic output_strobe_two_o, read_go;
	int errors = 0;
	int total_checks = 0;
	int trim_hi = 0;
	int rs_cnt = 0;
	capture_readout_control #(.DEPTH(16), .SHORT_WAIT_CYCLES(8), .LONG_WAIT_CYCLES(32),
		.RUN_CYCLES(RUN)) capture_readout_control_inst (.clock_i, .srst_i, .hsel_i, .haddr_i,
		.htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hrdata_o,
		.hreadyout_o, .hresp_o, .trim_request_i, .power_down_input_i, .range_select_pu_i,
		.range_select_pd_i, .output_transition_edge_pu_i, .output_transition_edge_pd_i,
		.trim_wait_select_i, .serial_shift_clock_i, .sample_clock_resync_i,
		.sample_clock_resync_p_i, .sample_clock_resync_n_i, .write_request_i, .read_request_i,
		.read_clock_i, .capture_reset_i, .sample_rise_i, .sample_fall_i, .sample_valid_i,
		.trim_active_o, .power_down_o, .full_scale_810_o, .ext_ctrl_enable_o, .ddr_enable_o,
		.output_transition_edge_o, .serial_select_o, .serial_in_line_o, .serial_clock_o,
		.sample_clock_resync_o, .output_port_one_o, .output_port_two_o, .output_port_two_oe_o,
		.output_strobe_one_o, .output_strobe_two_o);
	capture_reader capture_reader_inst (.clock_i, .read_go_i(read_go), .write_request_i,
		.output_port_one_i(output_port_one_o), .output_port_two_i(output_port_two_o),
		.output_strobe_one_i(output_strobe_one_o), .read_request_o(read_request_i),
		.read_clock_o(read_clock_i));
	initial begin
		clock_i = 1'b0;
		forever #20 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		if (trim_active_o === 1'b1) trim_hi++;
		if (sample_clock_resync_o === 1'b1) rs_cnt++;
	end
	task print_verdict;
		if (errors == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : print_verdict
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic bus(input logic wr, input logic [29:0] idx, input logic [31:0] wd);
		int w;
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		haddr_i <= {idx, 2'h0};
		hwrite_i <= wr;
		for (int ph = 0; ph < 2; ph++) begin
			w = 0;
			do begin
				@(posedge clock_i);
				w++;
			end while (hreadyout_o !== 1'b1 && w < 40);
			if (w >= 40) begin
				errors++;
				print_verdict();
			end
			if (ph == 0) begin
				htrans_i <= 2'h0;
				hwdata_i <= wd;
			end
		end
		rd = hrdata_o;
	endtask : bus
	task trim_try(input int lo, input int hi, input int e);
		trim_hi = 0;
		trim_request_i <= 1'b0;
		repeat (lo) @(posedge clock_i);
		trim_request_i <= 1'b1;
		repeat (hi + 40) @(posedge clock_i);
		chk("trim_run", e, trim_hi);
	endtask : trim_try
	task fill(input logic [7:0] b);
		write_request_i <= 1'b1;
		repeat (6) @(posedge clock_i);
		for (int k = 0; k < 4; k++) begin
			sample_rise_i <= b + 8'(8'h22 * k);
			sample_fall_i <= b + 8'(8'h22 * k) + 8'h11;
			sample_valid_i <= 1'b1;
			@(posedge clock_i);
		end
		sample_valid_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		write_request_i <= 1'b0;
		repeat (6) @(posedge clock_i);
		bus(1'b0, REG_IDX_STATUS, 32'h0000_0000);
		chk("fill", 32'h0000_0008, {19'h0, rd[28:16]});
	endtask : fill
	task drain(input logic [7:0] b, input logic dual);
		logic [7:0] r;
		capture_reader_inst.one_q.delete();
		capture_reader_inst.two_q.delete();
		capture_reader_inst.skew = 0;
		read_go <= 1'b1;
		repeat (120) @(posedge clock_i);
		read_go <= 1'b0;
		repeat (10) @(posedge clock_i);
		for (int k = 0; k < 4; k++) begin
			r = (b + 8'(8'h22 * k)) ^ 8'h80;
			if (dual) begin
				chk("port_two", r, capture_reader_inst.two_q[k]);
				chk("port_one", r + 8'h11, capture_reader_inst.one_q[k]);
			end else begin
				chk("port_one", r, capture_reader_inst.one_q[2 * k]);
				chk("port_one", r + 8'h11, capture_reader_inst.one_q[2 * k + 1]);
			end
		end
		chk("reads", dual ? 4 : 8, capture_reader_inst.one_q.size());
		chk("held", r + 8'h11, output_port_one_o);
		chk("two_oe", dual, output_port_two_oe_o);
		chk("skew", 0, capture_reader_inst.skew);
		bus(1'b0, REG_IDX_STATUS, 32'h0000_0000);
		chk("empty", 32'h0000_0000, {19'h0, rd[28:16]});
	endtask : drain
	initial begin
		srst_i = 1'b1; hsel_i = 1'b0; haddr_i = '0; htrans_i = 2'h0; hwrite_i = 1'b0;
		hsize_i = 3'h2; hwdata_i = '0; trim_request_i = 1'b1; power_down_input_i = 1'b0;
		range_select_pu_i = 1'b1; range_select_pd_i = 1'b1; trim_wait_select_i = 1'b0;
		output_transition_edge_pu_i = 1'b0; output_transition_edge_pd_i = 1'b0;
		serial_shift_clock_i = 1'b0; sample_clock_resync_i = 1'b0; read_go = 1'b0;
		sample_clock_resync_p_i = 1'b0; sample_clock_resync_n_i = 1'b1;
		write_request_i = 1'b0; capture_reset_i = 1'b0; sample_valid_i = 1'b0;
		sample_rise_i = 8'h00; sample_fall_i = 8'h00;
		repeat (8) @(posedge clock_i);
		srst_i <= 1'b0;
		repeat (120) @(posedge clock_i);
		chk("trim_powerup", RUN, trim_hi);
		trim_try(60, 100, 0);
		trim_try(90, 90, RUN);
		bus(1'b0, REG_IDX_CONFIG, 32'h0000_0000);
		chk("config", CONFIG_RESET, rd);
		bus(1'b0, REG_IDX_BUFCTRL, 32'h0000_0000);
		chk("bufctrl", BUFCTRL_RESET, rd);
		bus(1'b1, 30'h0000_0005, 32'hFFFF_FFFF);
		bus(1'b0, 30'h0000_0005, 32'h0000_0000);
		chk("unmapped", 32'h0000_0000, rd);
		bus(1'b1, REG_IDX_BUFCTRL, 32'hFFFF_FFFF);
		bus(1'b0, REG_IDX_BUFCTRL, 32'h0000_0000);
		chk("bufctrl", BUFCTRL_WMASK, rd);
		bus(1'b1, REG_IDX_BUFCTRL, 32'h0000_0000);
		for (int s = 0; s < 2; s++) begin
			bus(1'b1, REG_IDX_CONFIG, s ? CONFIG_WMASK : 32'h0000_0000);
			for (int w = 0; w < 2; w++) begin
				rs_cnt = 0;
				sample_clock_resync_i <= (w == 0);
				sample_clock_resync_p_i <= (w == 1);
				sample_clock_resync_n_i <= (w == 0);
				repeat (4) @(posedge clock_i);
				sample_clock_resync_i <= 1'b0;
				sample_clock_resync_p_i <= 1'b0;
				sample_clock_resync_n_i <= 1'b1;
				repeat (8) @(posedge clock_i);
				chk("resync", s == w, rs_cnt);
			end
		end
		for (int i = 0; i < 4; i++) begin
			range_select_pu_i <= i[1];
			range_select_pd_i <= i[0];
			output_transition_edge_pu_i <= i[1] | !i[0];
			output_transition_edge_pd_i <= i[1];
			serial_shift_clock_i <= i[1] ^ i[0];
			trim_wait_select_i <= 1'b1;
			repeat (8) @(posedge clock_i);
			bus(1'b0, REG_IDX_STATUS, 32'h0000_0000);
			chk("modes", (i[1] ^ i[0]) ? 32'h0000_0004 : (i[1] ? 32'h0000_0030 : 32'h0000_0008),
				rd & ((i[1] ^ i[0]) ? 32'h0000_000C : 32'h0000_003C));
			chk("ssel", i[1] ^ i[0], serial_select_o);
			chk("sclk", i[1] ^ i[0], serial_clock_o);
			chk("sdat", i == 2, serial_in_line_o);
			chk("ddr", i == 0, ddr_enable_o);
		end
		trim_wait_select_i <= 1'b0;
		power_down_input_i <= 1'b1;
		fill(8'h05);
		chk("pd", 1'b1, power_down_o);
		drain(8'h05, 1'b0);
		power_down_input_i <= 1'b0;
		bus(1'b1, REG_IDX_BUFCTRL, BUFCTRL_WMASK);
		fill(8'h60);
		drain(8'h60, 1'b1);
		fill(8'hA3);
		capture_reset_i <= 1'b1;
		repeat (6) @(posedge clock_i);
		capture_reset_i <= 1'b0;
		repeat (6) @(posedge clock_i);
		bus(1'b0, REG_IDX_STATUS, 32'h0000_0000);
		chk("cleared", 32'h0000_0000, {19'h0, rd[28:16]});
		print_verdict();
	end
endmodule : test_capture_readout_control
